// [common/ufe_pkg.sv]
// ufe_pkg: constants and types of the usb function endpoint register block
// assumes: byte-wide registers on a 16-bit address bus, five endpoints

package ufe_pkg;

  // endpoint count and bus geometry
  localparam int NUM_EP = 5;
  localparam int ADDR_W = 16;

  // one register address per endpoint, index 4 down to 0
  typedef logic [4:0][15:0] ufe_table_type;

  // fifo data ports
  localparam ufe_table_type DATA_OFS = {16'h1fd6, 16'h1fd2, 16'h1fd3, 16'h1fd4, 16'h1fd5};
  // endpoint service status
  localparam ufe_table_type STAT_OFS = {16'h1fde, 16'h1fda, 16'h1fdb, 16'h1fdc, 16'h1fdd};
  // endpoint configuration
  localparam ufe_table_type CFG_OFS = {16'h1fe6, 16'h1fe2, 16'h1fe3, 16'h1fe4, 16'h1fe5};
  // control and acknowledge
  localparam ufe_table_type ACK_OFS = {16'h1fa6, 16'h1fa2, 16'h1fa3, 16'h1fa4, 16'h1fa5};
  // packet length
  localparam ufe_table_type CNT_OFS = {16'h1fc4, 16'h1fc3, 16'h1fc2, 16'h1fc1, 16'h1fc0};
  // single address registers
  localparam logic [15:0] COMPAT_OFS = 16'h1fef;
  localparam logic [15:0] ADDR_OFS = 16'h1fee;

  // configuration fields
  localparam int CFG_EN = 7;
  localparam int CFG_TGL = 3;
  localparam int CFG_DIR = 2;
  localparam logic [7:0] CFG_MASK = 8'h8f;
  localparam logic [1:0] TYPE_CTRL = 2'h0;
  localparam logic [1:0] TYPE_ISO = 2'h1;
  localparam logic [1:0] TYPE_BULK = 2'h2;
  localparam logic [1:0] TYPE_INTR = 2'h3;

  // status fields
  localparam int STAT_STALL = 3;
  localparam int STAT_SETUP = 2;
  localparam int STAT_OUT = 1;
  localparam int STAT_TXC = 0;
  localparam logic [3:0] STAT_SETUP_ONLY = 4'h4;

  // acknowledge register: stored force-stall bit
  localparam int ACK_STALL_FORCE = 5;

  // single address enable and function enable
  localparam int COMPAT_SINGLE_ADDRESS_ENABLE = 7;
  localparam int ADDR_FEN = 7;

  // reset value, crc bytes in the length, fifo depths
  localparam logic [7:0] REG_RESET = 8'h00;
  localparam logic [6:0] CRC_BYTES = 7'h02;
  localparam logic [4:0][6:0] FIFO_DEPTH = {7'h08, 7'h08, 7'h40, 7'h40, 7'h08};

  // token kinds from the serial engine
  typedef enum logic [1:0] {
    PID_OUT = 2'b00,
    PID_IN = 2'b01,
    PID_SETUP = 2'b10
  } ufe_pid_type;

  // handshakes back to the serial engine
  typedef enum logic [1:0] {
    HS_ACK = 2'b00,
    HS_NAK = 2'b01,
    HS_STALL = 2'b10
  } ufe_hs_type;

endpackage

// [common/ufe_fifo_if.sv]
// ufe_fifo_if: port of one endpoint fifo
// assumes: all signals in the clk domain of the endpoint block
`timescale 1ns/10ps

interface ufe_fifo_if;
  logic push; // store wdata
  logic [7:0] wdata; // byte to store
  logic pop; // drop head byte
  logic [7:0] rdata; // head byte
  logic flush; // empty the fifo
  logic [6:0] level; // bytes held

  // controller side
  modport ctrl (output push, output wdata, output pop, output flush, input rdata, input level);
  // storage side
  modport store (input push, input wdata, input pop, input flush, output rdata, output level);
endinterface

// [hdl/ufe_fifo.sv]
// ufe_fifo: byte fifo of one endpoint, depth set by parameter
// assumes: synchronous controller, push on full and pop on empty ignored
`timescale 1ns/10ps

module ufe_fifo #(
  parameter logic [6:0] DEPTH = 7'h08
) (
  input wire logic clk,
  input wire logic reset,
  ufe_fifo_if.store bus
);

  // all fifo state
  typedef struct packed {
    logic [DEPTH-1:0][7:0] mem; // byte storage
    logic [5:0] wr; // write pointer
    logic [5:0] rd; // read pointer
    logic [6:0] level; // fill level
  } ufe_fifo_state_type;

  ufe_fifo_state_type s;
  ufe_fifo_state_type next_s;

  // pointer step with wrap at depth
  function automatic logic [5:0] step(input logic [5:0] p);
    step = (p == 6'(DEPTH - 7'h01)) ? 6'h00 : 6'(p + 6'h01);
  endfunction

  // next state: flush wins, then push and pop
  always_comb begin
    next_s = s;
    if (bus.flush) begin
      next_s.wr = 6'h00;
      next_s.rd = 6'h00;
      next_s.level = 7'h00;
    end else begin
      // store while room remains
      if (bus.push && s.level != DEPTH) begin
        next_s.mem[s.wr] = bus.wdata;
        next_s.wr = step(s.wr);
      end
      // drop head while data remains
      if (bus.pop && s.level != 7'h00) begin
        next_s.rd = step(s.rd);
      end
      next_s.level = 7'(s.level + {6'h00, bus.push && s.level != DEPTH}
                     - {6'h00, bus.pop && s.level != 7'h00});
    end
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // head byte and level
  assign bus.rdata = (s.level == 7'h00) ? 8'h00 : s.mem[s.rd];
  assign bus.level = s.level;

endmodule // ufe_fifo

// [hdl/ufe_top.sv]
// ufe_top: register and handshake logic of the usb function endpoints
// assumes: a serial engine decodes tokens and bytes and sends handshakes
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/10ps

module ufe_top (
  input wire logic clk,
  input wire logic reset,
  input wire logic [15:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  input wire logic tok_valid,
  input wire logic [1:0] tok_pid,
  input wire logic [6:0] tok_addr,
  input wire logic [2:0] tok_ep,
  input wire logic rx_valid,
  input wire logic [7:0] rx_byte,
  input wire logic rx_done,
  input wire logic rx_bad,
  output logic hs_valid,
  output logic [1:0] hs_code,
  output logic [4:0] ep_event
);

  // receive sequencer states
  typedef enum logic [0:0] {
    ST_IDLE = 1'b0,
    ST_RECV = 1'b1
  } ufe_state_type;

  // all block state
  typedef struct packed {
    ufe_state_type st; // sequencer state
    logic [2:0] cur_ep; // endpoint of the open packet
    logic accept; // open packet is stored
    logic setup; // open packet is a setup
    logic [4:0][7:0] cfg; // endpoint configuration
    logic [4:0][3:0] status; // endpoint service status
    logic [4:0] force_stall; // stall request per endpoint
    logic [4:0][6:0] cnt; // packet length with crc
    logic [7:0] compat; // single address register
    logic [7:0] dev_addr; // enable and function address
    logic [7:0] rdata; // read answer
    logic hs_valid; // handshake strobe
    logic [1:0] hs_code; // handshake kind
    logic [4:0] ep_event; // endpoint needs service
  } ufe_top_state_type;

  ufe_top_state_type s;
  ufe_top_state_type next_s;

  // fifo ports, one per endpoint
  ufe_fifo_if fifo_bus[ufe_pkg::NUM_EP] ();
  logic [4:0] push_v; // push per endpoint
  logic [4:0] pop_v; // pop per endpoint
  logic [4:0] flush_v; // flush per endpoint
  logic [4:0][7:0] wd_v; // byte per endpoint
  logic [4:0][7:0] rd_v; // head byte per endpoint

  // register address to endpoint index, 7 when absent
  function automatic logic [2:0] find_ep(input logic [15:0] a, input ufe_pkg::ufe_table_type t);
    find_ep = 3'h7;
    for (int i = 0; i < ufe_pkg::NUM_EP; i++) begin
      if (a == t[i]) begin
        find_ep = 3'(i);
      end
    end
  endfunction

  // one fifo per endpoint, depths 8 or 64
  generate
    for (genvar g = 0; g < ufe_pkg::NUM_EP; g++) begin : g_ep
      ufe_fifo #(
        .DEPTH(ufe_pkg::FIFO_DEPTH[g])
      ) u_fifo (
        .clk(clk),
        .reset(reset),
        .bus(fifo_bus[g].store)
      );
      assign fifo_bus[g].push = push_v[g];
      assign fifo_bus[g].wdata = wd_v[g];
      assign fifo_bus[g].pop = pop_v[g];
      assign fifo_bus[g].flush = flush_v[g];
      assign rd_v[g] = fifo_bus[g].rdata;
    end
  endgenerate

  // decoded register hits
  logic [2:0] hit_data;
  logic [2:0] hit_stat;
  logic [2:0] hit_cfg;
  logic [2:0] hit_ack;
  logic [2:0] hit_cnt;

  // token qualification
  logic ep_ok; // endpoint number exists
  logic fn_on; // function endpoints live
  logic tok_live; // token reaches an enabled endpoint
  logic [2:0] te; // token endpoint

  always_comb begin
    hit_data = find_ep(addr, ufe_pkg::DATA_OFS);
    hit_stat = find_ep(addr, ufe_pkg::STAT_OFS);
    hit_cfg = find_ep(addr, ufe_pkg::CFG_OFS);
    hit_ack = find_ep(addr, ufe_pkg::ACK_OFS);
    hit_cnt = find_ep(addr, ufe_pkg::CNT_OFS);
    te = tok_ep;
    ep_ok = (tok_ep < 3'h5);
    // single address makes function enable a don't care
    fn_on = s.compat[ufe_pkg::COMPAT_SINGLE_ADDRESS_ENABLE] || s.dev_addr[ufe_pkg::ADDR_FEN];
    tok_live = ep_ok && (tok_addr == s.dev_addr[6:0])
               && s.cfg[te][ufe_pkg::CFG_EN]
               && (te == 3'h0 || fn_on);
  end

  // next state: bus side first, link events after so sets win
  always_comb begin
    next_s = s;
    next_s.hs_valid = 1'b0;
    next_s.rdata = 8'h00;
    push_v = '0;
    pop_v = '0;
    flush_v = '0;
    wd_v = '0;

    // register writes; read-only and reserved bits ignored
    if (wr) begin
      if (hit_cfg != 3'h7) begin
        next_s.cfg[hit_cfg] = wdata & ufe_pkg::CFG_MASK;
      end else if (hit_ack != 3'h7) begin
        next_s.force_stall[hit_ack] = wdata[ufe_pkg::ACK_STALL_FORCE];
        // acknowledge bits clear flags and are not kept
        if (wdata[ufe_pkg::STAT_STALL]) begin
          next_s.status[hit_ack][ufe_pkg::STAT_STALL] = 1'b0;
        end
        if (wdata[ufe_pkg::STAT_SETUP]) begin
          next_s.status[hit_ack][ufe_pkg::STAT_SETUP] = 1'b0;
        end
        if (wdata[ufe_pkg::STAT_OUT]) begin
          next_s.status[hit_ack][ufe_pkg::STAT_OUT] = 1'b0;
        end
        if (wdata[ufe_pkg::STAT_TXC]) begin
          next_s.status[hit_ack][ufe_pkg::STAT_TXC] = 1'b0;
        end
      end else if (hit_data != 3'h7) begin
        // firmware byte into the fifo
        push_v[hit_data] = 1'b1;
        wd_v[hit_data] = wdata;
      end else if (addr == ufe_pkg::COMPAT_OFS) begin
        next_s.compat = wdata;
      end else if (addr == ufe_pkg::ADDR_OFS) begin
        next_s.dev_addr = wdata;
      end
    end

    // register reads, answer stands one cycle later
    if (rd) begin
      if (hit_cfg != 3'h7) begin
        next_s.rdata = s.cfg[hit_cfg] & ufe_pkg::CFG_MASK;
      end else if (hit_ack != 3'h7) begin
        next_s.rdata = 8'(s.force_stall[hit_ack]) << ufe_pkg::ACK_STALL_FORCE;
      end else if (hit_stat != 3'h7) begin
        next_s.rdata = {4'h0, s.status[hit_stat]};
      end else if (hit_cnt != 3'h7) begin
        next_s.rdata = {1'b0, s.cnt[hit_cnt]};
      end else if (hit_data != 3'h7) begin
        // head byte out, fifo advances
        next_s.rdata = rd_v[hit_data];
        pop_v[hit_data] = 1'b1;
      end else if (addr == ufe_pkg::COMPAT_OFS) begin
        next_s.rdata = s.compat;
      end else if (addr == ufe_pkg::ADDR_OFS) begin
        next_s.rdata = s.dev_addr;
      end
    end

    // packet bytes and end of packet
    case (s.st)
      ST_IDLE: begin
        // waiting for a token
      end
      ST_RECV: begin
        if (rx_valid && s.accept) begin
          push_v[s.cur_ep] = 1'b1;
          wd_v[s.cur_ep] = rx_byte;
          next_s.cnt[s.cur_ep] = 7'(s.cnt[s.cur_ep] + 7'h01);
        end
        if (rx_bad) begin
          // damaged packet: no handshake, host retries
          next_s.st = ST_IDLE;
        end else if (rx_done) begin
          next_s.st = ST_IDLE;
          next_s.hs_valid = 1'b1;
          if (s.accept) begin
            next_s.hs_code = ufe_pkg::HS_ACK;
            next_s.cfg[s.cur_ep][ufe_pkg::CFG_TGL] = !s.cfg[s.cur_ep][ufe_pkg::CFG_TGL];
            if (s.setup) begin
              next_s.status[0] = ufe_pkg::STAT_SETUP_ONLY;
            end else begin
              next_s.status[s.cur_ep][ufe_pkg::STAT_OUT] = 1'b1;
            end
          end else begin
            next_s.hs_code = ufe_pkg::HS_NAK;
          end
        end
      end
      default: begin
        next_s.st = ST_IDLE;
      end
    endcase

    // a token opens a transaction; disabled endpoints stay silent
    if (tok_valid) begin
      next_s.st = ST_IDLE;
      if (tok_live) begin
        next_s.cur_ep = te;
        if (tok_pid == ufe_pkg::PID_SETUP) begin
          if (te == 3'h0) begin
            // early setup may overwrite held data
            next_s.st = ST_RECV;
            next_s.accept = 1'b1;
            next_s.setup = 1'b1;
            flush_v[0] = 1'b1;
            next_s.cnt[0] = ufe_pkg::CRC_BYTES;
          end
        end else if (s.force_stall[te]) begin
          // stalled endpoint answers any data token
          next_s.hs_valid = 1'b1;
          next_s.hs_code = ufe_pkg::HS_STALL;
          next_s.status[te][ufe_pkg::STAT_STALL] = 1'b1;
        end else if (tok_pid == ufe_pkg::PID_OUT && (te == 3'h0 || !s.cfg[te][ufe_pkg::CFG_DIR])) begin
          next_s.st = ST_RECV;
          next_s.setup = 1'b0;
          // held data blocks new data
          next_s.accept = !s.status[te][ufe_pkg::STAT_OUT];
          if (!s.status[te][ufe_pkg::STAT_OUT]) begin
            flush_v[te] = 1'b1;
            next_s.cnt[te] = ufe_pkg::CRC_BYTES;
          end
        end else if (tok_pid == ufe_pkg::PID_IN && (te == 3'h0 || s.cfg[te][ufe_pkg::CFG_DIR])) begin
          // no packet loaded for the host
          next_s.hs_valid = 1'b1;
          next_s.hs_code = ufe_pkg::HS_NAK;
        end
      end
    end

    // service request per endpoint
    for (int i = 0; i < ufe_pkg::NUM_EP; i++) begin
      next_s.ep_event[i] = |next_s.status[i];
    end
  end

  // state register
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end

  // outputs straight from flip-flops
  assign rdata = s.rdata;
  assign hs_valid = s.hs_valid;
  assign hs_code = s.hs_code;
  assign ep_event = s.ep_event;

  // held data is nak'd at end of packet
  rx_nak_full_a: assert property (@(posedge clk) disable iff (reset)
    (s.st == ST_RECV && !s.accept && rx_done && !rx_bad && !tok_valid)
    |=> (hs_valid && hs_code == ufe_pkg::HS_NAK))
    else $error("held out data not nak'd");

  // accepted out data raises its flag with the ack
  ack_sets_out_a: assert property (@(posedge clk) disable iff (reset)
    (s.st == ST_RECV && s.accept && !s.setup && rx_done && !rx_bad && !tok_valid)
    |=> (hs_valid && hs_code == ufe_pkg::HS_ACK && s.status[$past(s.cur_ep)][ufe_pkg::STAT_OUT]))
    else $error("out ack without flag");

  // stall handshake marks stall sent
  stall_flag_a: assert property (@(posedge clk) disable iff (reset)
    (hs_valid && hs_code == ufe_pkg::HS_STALL) |-> s.status[s.cur_ep][ufe_pkg::STAT_STALL])
    else $error("stall sent flag missing");

  // setup leaves only the setup flag
  setup_only_a: assert property (@(posedge clk) disable iff (reset)
    (s.st == ST_RECV && s.setup && rx_done && !rx_bad && !tok_valid)
    |=> (s.status[0] == ufe_pkg::STAT_SETUP_ONLY && ep_event[0]))
    else $error("setup flags wrong");

  // parity bit flips on every ack
  toggle_flip_a: assert property (@(posedge clk) disable iff (reset)
    (hs_valid && hs_code == ufe_pkg::HS_ACK)
    |-> (s.cfg[s.cur_ep][ufe_pkg::CFG_TGL] != $past(s.cfg[s.cur_ep][ufe_pkg::CFG_TGL])))
    else $error("parity bit did not toggle");

  // disabled endpoint opens nothing
  disabled_quiet_a: assert property (@(posedge clk) disable iff (reset)
    (tok_valid && ep_ok && !s.cfg[tok_ep][ufe_pkg::CFG_EN]) |=> (s.st == ST_IDLE && !hs_valid))
    else $error("disabled endpoint answered");

  // setup acknowledge clears flag when no packet ends
  setup_clear_a: assert property (@(posedge clk) disable iff (reset)
    (wr && addr == ufe_pkg::ACK_OFS[0] && wdata[ufe_pkg::STAT_SETUP] && !(s.st == ST_RECV && rx_done))
    |=> !s.status[0][ufe_pkg::STAT_SETUP])
    else $error("setup flag not cleared");

  // out acknowledge clears flag when no packet ends
  out_clear_a: assert property (@(posedge clk) disable iff (reset)
    (wr && addr == ufe_pkg::ACK_OFS[1] && wdata[ufe_pkg::STAT_OUT] && !(s.st == ST_RECV && rx_done))
    |=> !s.status[1][ufe_pkg::STAT_OUT])
    else $error("out flag not cleared");

  // length register top bit and status register bit 7 read zero
  read_zero_a: assert property (@(posedge clk) disable iff (reset)
    (rd && (hit_cnt != 3'h7 || hit_stat != 3'h7)) |=> (rdata[7] == 1'b0))
    else $error("reserved bit read one");

  // configuration reserved bits read zero
  cfg_reserved_a: assert property (@(posedge clk) disable iff (reset)
    (rd && hit_cfg != 3'h7) |=> (rdata[6:4] == 3'h0))
    else $error("config reserved bits nonzero");

endmodule // ufe_top

// [tb/ufe_host_model.sv]
// ufe_host_model: usb host as seen through the decoded strobes of the serial engine
// assumes: shares clk with the block; the bench calls its tasks to start transactions
`timescale 1ns/10ps

module ufe_host_model (
  input wire logic clk,
  output logic tok_valid,
  output logic [1:0] tok_pid,
  output logic [6:0] tok_addr,
  output logic [2:0] tok_ep,
  output logic rx_valid,
  output logic [7:0] rx_byte,
  output logic rx_done,
  output logic rx_bad
);
  // idle bus at time zero
  initial begin
    tok_valid = 1'b0;
    tok_pid = 2'b11;
    tok_addr = 7'h7f;
    tok_ep = 3'h7;
    rx_valid = 1'b0;
    rx_byte = 8'h5a;
    rx_done = 1'b0;
    rx_bad = 1'b0; // damaged packets only through bad_pkt
  end

  // out token, one byte, then a damaged end
  task automatic bad_pkt(input logic [6:0] a, input logic [2:0] ep);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok_pid <= ufe_pkg::PID_OUT;
    tok_addr <= a;
    tok_ep <= ep;
    @(posedge clk);
    tok_valid <= 1'b0;
    rx_valid <= 1'b1;
    @(posedge clk);
    rx_valid <= 1'b0;
    rx_bad <= 1'b1;
    @(posedge clk);
    rx_bad <= 1'b0;
  endtask

  // token, then n payload bytes counting up from base, then a good end for out and setup tokens
  task automatic pkt(input logic [1:0] pid, input logic [6:0] a, input logic [2:0] ep, input int n,
                     input logic [7:0] base);
    @(posedge clk);
    tok_valid <= 1'b1;
    tok_pid <= pid;
    tok_addr <= a;
    tok_ep <= ep;
    @(posedge clk);
    tok_valid <= 1'b0;
    tok_ep <= ~ep; // released lines show garbage, not the last token
    tok_addr <= ~a;
    for (int i = 0; i < n; i++) begin
      rx_valid <= 1'b1;
      rx_byte <= base + 8'(i);
      @(posedge clk);
    end
    rx_valid <= 1'b0;
    rx_byte <= ~rx_byte; // no stale byte between packets
    // in tokens carry no data packet from the host
    if (pid != ufe_pkg::PID_IN) begin
      rx_done <= 1'b1;
      @(posedge clk);
      rx_done <= 1'b0;
    end
  endtask
endmodule // ufe_host_model

// [tb/ufe_top_tb.sv]
// ufe_top_tb: self-checking bench of the endpoint register block
// assumes: host model drives the link side, bench plays the firmware on the register port
`timescale 1ns/10ps

module ufe_top_tb;
  logic clk, reset, wr, rd, tok_valid, rx_valid, rx_done, rx_bad, hs_valid;
  logic [15:0] addr;
  logic [7:0] wdata, rdata, rx_byte, got;
  logic [1:0] tok_pid, hs_code, hs_last;
  logic [6:0] tok_addr;
  logic [2:0] tok_ep;
  logic [4:0] ep_event;
  int err_count, n_tests, hs_count, cycles;

  ufe_top uut (.clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_addr(tok_addr), .tok_ep(tok_ep), .rx_valid(rx_valid),
    .rx_byte(rx_byte), .rx_done(rx_done), .rx_bad(rx_bad), .hs_valid(hs_valid), .hs_code(hs_code),
    .ep_event(ep_event));
  ufe_host_model host (.clk(clk), .tok_valid(tok_valid), .tok_pid(tok_pid), .tok_addr(tok_addr),
    .tok_ep(tok_ep), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_done(rx_done), .rx_bad(rx_bad));

  // 100 ns clock
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // handshake counter and timeout guard
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (hs_valid === 1'b1) begin
      hs_count <= hs_count + 1;
      hs_last <= hs_code;
    end
    if (cycles == 20000) begin
      err_count = err_count + 1;
      results();
    end
  end

  // one comparison
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  // one-cycle register write
  task automatic wr_reg(input logic [15:0] a, input logic [7:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
    wdata <= ~d;
  endtask

  // one-cycle read, data taken in the following cycle
  task automatic rd_reg(input logic [15:0] a, output logic [7:0] d);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    @(negedge clk);
    d = rdata;
  endtask

  // read and compare
  task automatic chk_reg(input string nm, input logic [15:0] a, input logic [7:0] exp);
    rd_reg(a, got);
    chk(nm, got, exp);
  endtask

  // host transaction, then count handshakes; code checked only when one is expected
  task automatic xfer(input logic [1:0] pid, input logic [2:0] ep, input int n, input logic [7:0] base,
                      input int exp_n, input logic [1:0] exp_code);
    int h0;
    h0 = hs_count;
    host.pkt(pid, 7'h05, ep, n, base);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("handshake count", 8'(hs_count - h0), 8'(exp_n));
    if (exp_n != 0) chk("handshake code", {6'h0, hs_last}, {6'h0, exp_code});
  endtask

  // reset values, reserved bits, read-only and unmapped places
  task automatic t_regs;
    for (int e = 0; e < 5; e++) begin
      chk_reg("config reset", ufe_pkg::CFG_OFS[e], 8'h00);
      chk_reg("status reset", ufe_pkg::STAT_OFS[e], 8'h00);
    end
    chk_reg("address reset", ufe_pkg::ADDR_OFS, 8'h00);
    wr_reg(ufe_pkg::CFG_OFS[2], 8'hff);
    chk_reg("config reserved", ufe_pkg::CFG_OFS[2], 8'h8f);
    for (int t = 0; t < 4; t++) begin
      wr_reg(ufe_pkg::CFG_OFS[2], 8'h74 | 8'(t));
      chk_reg("config type dir", ufe_pkg::CFG_OFS[2], 8'h04 | 8'(t));
    end
    wr_reg(ufe_pkg::CFG_OFS[2], 8'h00);
    wr_reg(ufe_pkg::STAT_OFS[1], 8'hff);
    chk_reg("status read only", ufe_pkg::STAT_OFS[1], 8'h00);
    wr_reg(16'h1f00, 8'hff);
    chk_reg("unmapped", 16'h1f00, 8'h00);
  endtask

  // bulk out on endpoint 1, then a second out while the flag stands
  task automatic t_out;
    wr_reg(ufe_pkg::CFG_OFS[1], 8'h82);
    wr_reg(ufe_pkg::ADDR_OFS, 8'h85);
    chk_reg("address", ufe_pkg::ADDR_OFS, 8'h85);
    xfer(ufe_pkg::PID_OUT, 3'd1, 3, 8'h10, 1, ufe_pkg::HS_ACK);
    chk("event", {3'h0, ep_event}, 8'h02);
    xfer(ufe_pkg::PID_OUT, 3'd1, 2, 8'h70, 1, ufe_pkg::HS_NAK);
    chk_reg("status out", ufe_pkg::STAT_OFS[1], 8'h02);
    chk_reg("toggle", ufe_pkg::CFG_OFS[1], 8'h8a);
    chk_reg("length", ufe_pkg::CNT_OFS[1], 8'h05);
    for (int i = 0; i < 3; i++) chk_reg("fifo out", ufe_pkg::DATA_OFS[1], 8'h10 + 8'(i));
    wr_reg(ufe_pkg::ACK_OFS[1], 8'h42);
    chk_reg("status cleared", ufe_pkg::STAT_OFS[1], 8'h00);
    chk("event cleared", {3'h0, ep_event}, 8'h00);
  endtask

  // setup on endpoint 0 and its acknowledge
  task automatic t_setup;
    wr_reg(ufe_pkg::CFG_OFS[0], 8'h80);
    xfer(ufe_pkg::PID_SETUP, 3'd0, 8, 8'h40, 1, ufe_pkg::HS_ACK);
    chk_reg("status setup", ufe_pkg::STAT_OFS[0], 8'h04);
    chk_reg("length setup", ufe_pkg::CNT_OFS[0], 8'h0a);
    for (int i = 0; i < 8; i++) chk_reg("fifo setup", ufe_pkg::DATA_OFS[0], 8'h40 + 8'(i));
    wr_reg(ufe_pkg::ACK_OFS[0], 8'h05);
    chk_reg("setup cleared", ufe_pkg::STAT_OFS[0], 8'h00);
    chk_reg("ack not stored", ufe_pkg::ACK_OFS[0], 8'h00);
  endtask

  // forced stall answered to an in token, then cleared
  task automatic t_stall;
    wr_reg(ufe_pkg::CFG_OFS[3], 8'h86);
    wr_reg(ufe_pkg::ACK_OFS[3], 8'h20);
    xfer(ufe_pkg::PID_IN, 3'd3, 0, 8'h00, 1, ufe_pkg::HS_STALL);
    chk_reg("stall sent", ufe_pkg::STAT_OFS[3], 8'h08);
    wr_reg(ufe_pkg::ACK_OFS[3], 8'h08);
    chk_reg("stall cleared", ufe_pkg::STAT_OFS[3], 8'h00);
  endtask

  // fill the fifos of endpoints 1 and 3 past full through their data ports, then drain past empty
  task automatic t_depth;
    int e, d;
    for (int k = 0; k < 2; k++) begin
      e = (k == 0) ? 1 : 3;
      d = int'(ufe_pkg::FIFO_DEPTH[e]);
      for (int i = 0; i < d + 2; i++) wr_reg(ufe_pkg::DATA_OFS[e], 8'(i));
      for (int i = 0; i <= d; i++) chk_reg("fifo depth", ufe_pkg::DATA_OFS[e], (i < d) ? 8'(i) : 8'h00);
    end
  endtask

  // disabled endpoint, then function enable against single address enable
  task automatic t_enable;
    xfer(ufe_pkg::PID_OUT, 3'd2, 2, 8'h20, 0, ufe_pkg::HS_ACK);
    chk_reg("disabled status", ufe_pkg::STAT_OFS[2], 8'h00);
    wr_reg(ufe_pkg::ADDR_OFS, 8'h05);
    wr_reg(ufe_pkg::CFG_OFS[4], 8'h83);
    xfer(ufe_pkg::PID_OUT, 3'd4, 2, 8'h30, 0, ufe_pkg::HS_ACK);
    wr_reg(ufe_pkg::COMPAT_OFS, 8'h80);
    chk_reg("compat", ufe_pkg::COMPAT_OFS, 8'h80);
    xfer(ufe_pkg::PID_OUT, 3'd4, 2, 8'h30, 1, ufe_pkg::HS_ACK);
    chk_reg("status single", ufe_pkg::STAT_OFS[4], 8'h02);
  endtask

  // damaged packet on endpoint 1: no handshake, no flag, no toggle
  task automatic t_bad;
    int h0;
    h0 = hs_count;
    host.bad_pkt(7'h05, 3'd1);
    repeat (4) @(posedge clk);
    @(negedge clk);
    chk("bad handshake", 8'(hs_count - h0), 8'h00);
    chk_reg("bad status", ufe_pkg::STAT_OFS[1], 8'h00);
    chk_reg("bad toggle", ufe_pkg::CFG_OFS[1], 8'h8a);
  endtask

  // counts, verdict, end of run
  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask

  // main sequence
  initial begin
    reset = 1'b1;
    wr = 1'b0;
    rd = 1'b0;
    addr = 16'h0000;
    wdata = 8'h00;
    err_count = 0;
    n_tests = 0;
    hs_count = 0;
    cycles = 0;
    hs_last = 2'b11;
    repeat (8) @(posedge clk);
    reset <= 1'b0;
    t_regs();
    t_out();
    t_setup();
    t_stall();
    t_depth();
    t_enable();
    t_bad();
    results();
  end
endmodule // ufe_top_tb
